// ==== inc/port_mux_pkg.sv ====
// port_mux_pkg: register map, field layout, reset values and bus states of the port pin block.
// assumes one 32-bit AXI4-Lite slave, one register per aligned word, eight pins per port.
// Operation
// - clamp each digital input to ground during power-down, power-save or standby
// - no clamp on a pin whose external interrupt request is enabled
// - clamp stays on for an interrupt-capable pin whose request is disabled
// - clamp release on a held-high disabled edge pin sets its flag on wake
// - pull-ups are off while reset is asserted
// - without pull-up force, pull-up on only for direction 0, value 1, disable 0
// - with pull-up force, the force value alone sets the pull-up
// - driver enable comes from direction force value if forced, else direction bit
// - forced direction: driver on when force value set, off when clear
// - enabled driver drives force value if forced, else the stored output value
// - forced output value equals the force value, ignoring the stored bit
// - peripheral invert strobe inverts the stored output value bit
// - input enable comes from input force value if forced, else sleep state
// - forced input enable follows the force value regardless of sleep
// - raw input to peripherals taken after the trigger, before the synchroniser
// - analog path goes straight to the pad, past all digital gating
// - strobes shared per port, clock, sleep and pull-up disable shared; forces per pin; the code takes one invert strobe bit per pin
// - each pin offers its converter channel and pin-change source of same index
// - without forces direction 1 is output driving stored value, 0 is input
// - writing one to an input register bit inverts the stored output value
package port_mux_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_EDGE = 8'h14;
  localparam int SEL_W = 6;
  localparam int CTRL_PUD_BIT = 0;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_EDGE = 16'h0000;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_ANY = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_type;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_type;
endpackage

// ==== inc/pin_mux_if.sv ====
// pin_mux_if: per-pin settings and forces into the pad mux, pad and input results out.
// assumes one port of N pins; the control end is the register block.
`timescale 1ns/1ps
interface pin_mux_if #(parameter int N = 8);
  logic [N-1:0] dir;
  logic [N-1:0] outv;
  logic global_pullup_disable;
  logic deep_sleep;
  logic [N-1:0] irq_en;
  logic [N-1:0] pu_fe;
  logic [N-1:0] pu_fv;
  logic [N-1:0] dir_fe;
  logic [N-1:0] dir_fv;
  logic [N-1:0] ov_fe;
  logic [N-1:0] ov_fv;
  logic [N-1:0] ib_fe;
  logic [N-1:0] ib_fv;
  logic [N-1:0] pad_in;
  logic [N-1:0] pad_out;
  logic [N-1:0] pad_oe;
  logic [N-1:0] pad_pullup;
  logic [N-1:0] raw_in;
  logic [N-1:0] pin_sync;
  logic [N-1:0] analog;
  modport core (input dir, outv, global_pullup_disable, deep_sleep, irq_en, pu_fe, pu_fv, dir_fe, dir_fv,
    ov_fe, ov_fv, ib_fe, ib_fv, pad_in,
    output pad_out, pad_oe, pad_pullup, raw_in, pin_sync, analog);
  modport ctrl (output dir, outv, global_pullup_disable, deep_sleep, irq_en, pu_fe, pu_fv, dir_fe, dir_fv,
    ov_fe, ov_fv, ib_fe, ib_fv, pad_in,
    input pad_out, pad_oe, pad_pullup, raw_in, pin_sync, analog);
endinterface

// ==== logic/pin_mux_core.sv ====
// pin_mux_core: merges register settings with peripheral forces per pin, clamps inputs
// in deep sleep and synchronises the pin level. assumes forces come straight from peripherals.
`timescale 1ns/1ps
module pin_mux_core
  import port_mux_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset,
  pin_mux_if.core pm
);
  logic [N-1:0] pull_req;
  logic [N-1:0] drv_en;
  logic [N-1:0] drv_val;
  logic [N-1:0] in_en;
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // output side: forces are combinational so a peripheral takes the pin at once
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      assign pull_req[i] = pm.pu_fe[i] ? pm.pu_fv[i] :
        (!pm.dir[i] && pm.outv[i] && !pm.global_pullup_disable);
      assign drv_en[i] = pm.dir_fe[i] ? pm.dir_fv[i] : pm.dir[i];
      assign drv_val[i] = pm.ov_fe[i] ? pm.ov_fv[i] : pm.outv[i];
      // sleep clamp unless the external request keeps the input live
      assign in_en[i] = pm.ib_fe[i] ? pm.ib_fv[i] :
        !(pm.deep_sleep && !pm.irq_en[i]);
    end
  endgenerate

  // tri-state and no pull-up while reset holds, even with no clock running
  assign pm.pad_pullup = reset ? '0 : pull_req;
  assign pm.pad_oe = reset ? '0 : drv_en;
  assign pm.pad_out = drv_en & drv_val;
  assign pm.raw_in = pm.pad_in & in_en;
  assign pm.analog = pm.pad_in;

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser for the readable pin level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pm.raw_in;
      sync2_r <= sync1_r;
    end
  end
  assign pm.pin_sync = sync2_r;
endmodule // pin_mux_core

// ==== logic/port_pin_override_mux.sv ====
// port_pin_override_mux: one eight-pin port with AXI4-Lite registers, peripheral
// override inputs, deep-sleep clamping and pin edge flags.
// assumes pad buffers outside combine pad_out, pad_oe and pad_pullup into the wire.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module port_pin_override_mux
  import port_mux_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic deep_sleep,
  input wire logic [N-1:0] ext_irq_en,
  input wire logic [N-1:0] pullup_force_en,
  input wire logic [N-1:0] pullup_force_val,
  input wire logic [N-1:0] dir_force_en,
  input wire logic [N-1:0] dir_force_val,
  input wire logic [N-1:0] outval_force_en,
  input wire logic [N-1:0] outval_force_val,
  input wire logic [N-1:0] outval_invert_en,
  input wire logic [N-1:0] inbuf_force_en,
  input wire logic [N-1:0] inbuf_force_val,
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pullup,
  output logic [N-1:0] raw_pin_input,
  output logic [N-1:0] pin_change_irq_src,
  output logic [N-1:0] analog_pad_path,
  output logic [N-1:0] pin_edge_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [SEL_W-1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    reg_sel = {w == OFS_EDGE, w == OFS_FLAG, w == OFS_CTRL,
      w == OFS_IN, w == OFS_OUT, w == OFS_DIR};
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    lane_merge = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  wr_state_type wst_r;
  wr_state_type wst_nxt;
  rd_state_type rst_r;
  rd_state_type rst_nxt;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [N-1:0] dir_r;
  logic [N-1:0] dir_nxt;
  logic [N-1:0] out_r;
  logic [N-1:0] out_nxt;
  logic pud_r;
  logic pud_nxt;
  logic [2*N-1:0] edge_r;
  logic [2*N-1:0] edge_nxt;
  logic [N-1:0] flag_r;
  logic [N-1:0] flag_nxt;
  logic [N-1:0] prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // pad mux, one instance serves the whole port
  pin_mux_if #(.N(N)) pm ();

  // one pull-up disable and sleep for all pins; request enables and forces per pin
  assign pm.dir = dir_r;
  assign pm.outv = out_r;
  assign pm.global_pullup_disable = pud_r;
  assign pm.deep_sleep = deep_sleep;
  assign pm.irq_en = ext_irq_en;
  assign pm.pu_fe = pullup_force_en;
  assign pm.pu_fv = pullup_force_val;
  assign pm.dir_fe = dir_force_en;
  assign pm.dir_fv = dir_force_val;
  assign pm.ov_fe = outval_force_en;
  assign pm.ov_fv = outval_force_val;
  assign pm.ib_fe = inbuf_force_en;
  assign pm.ib_fv = inbuf_force_val;
  assign pm.pad_in = pad_in;

  pin_mux_core #(.N(N)) u_core (
    .sys_clk(sys_clk),
    .reset(reset),
    .pm(pm)
  );

  // pad-facing paths stay combinational: forces must act in the cycle they rise
  assign pad_out = pm.pad_out;
  assign pad_oe = pm.pad_oe;
  assign pad_pullup = pm.pad_pullup;
  assign raw_pin_input = pm.raw_in;
  assign pin_change_irq_src = pm.raw_in;
  assign analog_pad_path = pm.analog;

  ////////////////////////////////////////////////////////////////////////////
  // write channel decode
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [SEL_W-1:0] wsel;
  logic [31:0] wmerge;
  logic [N-1:0] wbits;
  logic [N-1:0] toggle;
  logic [N-1:0] flag_clr;

  assign aw_take = awvalid && awready_r;
  assign w_take = wvalid && wready_r;
  assign wr_go = (wst_r == WR_COLLECT) && aw_held_r && w_held_r;
  assign wsel = wr_go ? reg_sel(awaddr_r) : '0;
  assign wmerge = lane_merge(32'h0000_0000, wdata_r, wstrb_r);
  assign wbits = wmerge[N-1:0];
  // a one written to the input register inverts the stored value
  assign toggle = (wsel[2] ? wbits : '0) | outval_invert_en;
  assign flag_clr = wsel[4] ? wbits : '0;

  logic [31:0] dir_word;
  logic [31:0] edge_word;
  assign dir_word = wsel[0] ? lane_merge({{(32-N){1'b0}}, dir_r}, wdata_r, wstrb_r)
    : {{(32-N){1'b0}}, dir_r};
  assign dir_nxt = dir_word[N-1:0];
  assign out_nxt = (wsel[1] ? wbits : out_r) ^ toggle;
  assign pud_nxt = (wsel[3] && wstrb_r[0]) ? wdata_r[CTRL_PUD_BIT] : pud_r;
  assign edge_word = wsel[5]
    ? lane_merge({{(32-2*N){1'b0}}, edge_r}, wdata_r, wstrb_r)
    : {{(32-2*N){1'b0}}, edge_r};
  assign edge_nxt = edge_word[2*N-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin edge flags; a clamp release reads as a rising edge on wake
  logic [N-1:0] hit;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_edge
      logic rise;
      logic fall;
      assign rise = pm.pin_sync[i] && !prev_r[i];
      assign fall = !pm.pin_sync[i] && prev_r[i];
      assign hit[i] = (edge_r[2*i +: 2] == EDGE_ANY && (rise || fall)) ||
        (edge_r[2*i +: 2] == EDGE_FALL && fall) ||
        (edge_r[2*i +: 2] == EDGE_RISE && rise);
    end
  endgenerate
  // a new edge wins over a clear in the same cycle
  assign flag_nxt = (flag_r & ~flag_clr) | hit;

  ////////////////////////////////////////////////////////////////////////////
  // write state machine
  always_comb begin
    wst_nxt = wst_r;
    case (wst_r)
      WR_COLLECT: begin
        if (wr_go) begin
          wst_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          wst_nxt = WR_COLLECT;
        end
      end
      default: wst_nxt = WR_COLLECT;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wst_r <= WR_COLLECT;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (reg_sel(awaddr_r) == '0) ? RESP_SLVERR : RESP_OKAY;
      end
      if (wst_r == WR_RESP && bready) begin
        bvalid_r <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (aw_take) begin
      awaddr_r <= awaddr;
    end
    if (w_take) begin
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dir_r <= RST_DIR;
      out_r <= RST_OUT;
      pud_r <= RST_CTRL[CTRL_PUD_BIT];
      edge_r <= RST_EDGE;
      flag_r <= '0;
      prev_r <= '0;
    end else begin
      dir_r <= dir_nxt[N-1:0];
      out_r <= out_nxt;
      pud_r <= pud_nxt;
      edge_r <= edge_nxt[2*N-1:0];
      flag_r <= flag_nxt;
      prev_r <= pm.pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic rd_take;
  logic [SEL_W-1:0] rsel;
  logic [31:0] rmux;

  assign rd_take = arvalid && arready_r;
  assign rsel = reg_sel(araddr);
  assign rmux = ({32{rsel[0]}} & {{(32-N){1'b0}}, dir_r}) |
    ({32{rsel[1]}} & {{(32-N){1'b0}}, out_r}) |
    ({32{rsel[2]}} & {{(32-N){1'b0}}, pm.pin_sync}) |
    ({32{rsel[3]}} & {31'h0000_0000, pud_r}) |
    ({32{rsel[4]}} & {{(32-N){1'b0}}, flag_r}) |
    ({32{rsel[5]}} & {{(32-2*N){1'b0}}, edge_r});

  always_comb begin
    rst_nxt = rst_r;
    case (rst_r)
      RD_IDLE: begin
        if (rd_take) begin
          rst_nxt = RD_RESP;
        end
      end
      RD_RESP: begin
        if (rready) begin
          rst_nxt = RD_IDLE;
        end
      end
      default: rst_nxt = RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_r <= RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      rst_r <= rst_nxt;
      if (rd_take) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rmux;
        rresp_r <= (rsel == '0) ? RESP_SLVERR : RESP_OKAY;
      end else if (rst_r == RD_RESP && rready) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs straight from flip-flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign pin_edge_flag = flag_r;
endmodule // port_pin_override_mux

// ==== verif/port_mux_asserts.sv ====
// port_mux_asserts: pad-side relations of the port pin block.
// assumes it is bound to port_pin_override_mux and sees only its ports.
`timescale 1ns/1ps
module port_mux_asserts
  import port_mux_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic deep_sleep,
  input wire logic [N-1:0] ext_irq_en,
  input wire logic [N-1:0] pullup_force_en,
  input wire logic [N-1:0] pullup_force_val,
  input wire logic [N-1:0] dir_force_en,
  input wire logic [N-1:0] dir_force_val,
  input wire logic [N-1:0] outval_force_en,
  input wire logic [N-1:0] outval_force_val,
  input wire logic [N-1:0] inbuf_force_en,
  input wire logic [N-1:0] inbuf_force_val,
  input wire logic [N-1:0] pad_in,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup,
  input wire logic [N-1:0] raw_pin_input,
  input wire logic [N-1:0] analog_pad_path
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  property p_dir_force; |dir_force_en |-> ((pad_oe ^ dir_force_val) & dir_force_en) == '0;
  endproperty
  a_dir_force: assert property (p_dir_force) else $error("forced direction ignored");
  property p_pull_force; |pullup_force_en |->
    ((pad_pullup ^ pullup_force_val) & pullup_force_en) == '0;
  endproperty
  a_pull_force: assert property (p_pull_force) else $error("forced pull-up ignored");
  property p_val_force; |(outval_force_en & pad_oe) |->
    ((pad_out ^ outval_force_val) & outval_force_en & pad_oe) == '0;
  endproperty
  a_val_force: assert property (p_val_force) else $error("forced value ignored");
  property p_drv_off; (pad_out & ~pad_oe) == '0;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("value with driver off");
  // the clamp must hold for the whole sleep, so it is checked every cycle of it
  property p_clamp; deep_sleep |-> (raw_pin_input & ~ext_irq_en & ~inbuf_force_en) == '0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped");
  property p_irq_live; |ext_irq_en |->
    ((raw_pin_input ^ pad_in) & ext_irq_en & ~inbuf_force_en) == '0;
  endproperty
  a_irq_live: assert property (p_irq_live) else $error("interrupt pin clamped");
  property p_in_force; |inbuf_force_en |->
    ((raw_pin_input ^ (pad_in & inbuf_force_val)) & inbuf_force_en) == '0;
  endproperty
  a_in_force: assert property (p_in_force) else $error("forced input ignored");
  property p_analog; $changed(pad_in) |-> analog_pad_path == pad_in;
  endproperty
  a_analog: assert property (p_analog) else $error("analog path gated");
  property p_pull_rel; $fell(reset) |-> (pad_pullup & ~pullup_force_en) == '0;
  endproperty
  a_pull_rel: assert property (p_pull_rel) else $error("pull-up kept over reset");
  c_sleep: cover property (deep_sleep && ext_irq_en != '0);
  c_dir: cover property (dir_force_en != '0);
  c_inbuf: cover property (inbuf_force_en != '0);
endmodule // port_mux_asserts

bind port_pin_override_mux port_mux_asserts #(.N(N)) u_port_mux_asserts (.sys_clk, .reset,
  .deep_sleep, .ext_irq_en, .pullup_force_en, .pullup_force_val, .dir_force_en, .dir_force_val,
  .outval_force_en, .outval_force_val, .inbuf_force_en, .inbuf_force_val, .pad_in, .pad_out,
  .pad_oe, .pad_pullup, .raw_pin_input, .analog_pad_path);

// ==== verif/periph_model.sv ====
// periph_model: stands in for the peripherals that own alternate pin functions.
// assumes the bench packs eight force vectors and the invert strobe into plan; they change after a clock edge.
`timescale 1ns/1ps
module periph_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [71:0] plan,
  input wire logic [7:0] raw_pin_input,
  output logic [7:0] pullup_force_en,
  output logic [7:0] pullup_force_val,
  output logic [7:0] dir_force_en,
  output logic [7:0] dir_force_val,
  output logic [7:0] outval_force_en,
  output logic [7:0] outval_force_val,
  output logic [7:0] outval_invert_en,
  output logic [7:0] inbuf_force_en,
  output logic [7:0] inbuf_force_val,
  output logic [7:0] raw_seen
);
  logic [71:0] force_r;
  logic [7:0] meta_r;
  // forces leave straight from a flop, so the mux must act on them in that cycle
  assign {pullup_force_en, pullup_force_val, dir_force_en, dir_force_val, outval_force_en,
    outval_force_val, outval_invert_en, inbuf_force_en, inbuf_force_val} = force_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      force_r <= '0;
      meta_r <= '0;
      raw_seen <= '0;
    end else begin
      force_r <= plan;
      meta_r <= raw_pin_input;
      raw_seen <= meta_r;
    end
  end
endmodule // periph_model

// ==== verif/port_pin_override_mux_tb.sv ====
// port_pin_override_mux_tb: bus, force, sleep-clamp and reset scenarios for one port.
// assumes the peripheral model supplies every force; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
module port_pin_override_mux_tb;
  import port_mux_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic deep_sleep = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pad_in = 8'h00, ext_irq_en = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [71:0] plan = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pad_out, pad_oe, pad_pullup, raw_pin_input, pin_change_irq_src, analog_pad_path;
  logic [7:0] pin_edge_flag, raw_seen;
  logic [7:0] pullup_force_en, pullup_force_val, dir_force_en, dir_force_val, outval_force_en;
  logic [7:0] outval_force_val, outval_invert_en, inbuf_force_en, inbuf_force_val;
  int failures = 0;
  int checks = 0;

  always #5 sys_clk = ~sys_clk;

  port_pin_override_mux #(.N(8)) u_port_pin_override_mux (.sys_clk, .reset, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .deep_sleep, .ext_irq_en, .pullup_force_en,
    .pullup_force_val, .dir_force_en, .dir_force_val, .outval_force_en, .outval_force_val,
    .outval_invert_en, .inbuf_force_en, .inbuf_force_val, .pad_in, .pad_out, .pad_oe,
    .pad_pullup, .raw_pin_input, .pin_change_irq_src, .analog_pad_path, .pin_edge_flag);
  periph_model u_periph_model (.sys_clk, .reset, .plan, .raw_pin_input, .pullup_force_en,
    .pullup_force_val, .dir_force_en, .dir_force_val, .outval_force_en, .outval_force_val,
    .outval_invert_en, .inbuf_force_en, .inbuf_force_val, .raw_seen);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pad side is sampled mid-cycle, away from the edge that moved the inputs
  task automatic pads(input logic [23:0] exp);
    @(negedge sys_clk);
    chk({8'h00, pad_oe, pad_out, pad_pullup}, {8'h00, exp});
    @(posedge sys_clk);
  endtask

  task automatic ins(input logic [23:0] exp);
    @(negedge sys_clk);
    chk({8'h00, analog_pad_path, raw_pin_input, pin_change_irq_src}, {8'h00, exp});
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd_chk(OFS_DIR, 32'h0000_0000);
    rd_chk(OFS_OUT, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    pads(24'h00_0000);
  endtask

  task automatic t_gpio();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_DIR, 32'h0000_0033);
    wr(OFS_OUT, 32'h0000_0055);
    pads(24'h33_1144);
    wr(OFS_CTRL, 32'h0000_0001);
    pads(24'h33_1100);
    axi_wr(8'h40, 32'h0000_00ff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h40, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_toggle();
    wr(OFS_IN, 32'h0000_000f);
    rd_chk(OFS_OUT, 32'h0000_005a);
    plan <= {48'h0, 8'h81, 16'h0000};
    @(posedge sys_clk);
    plan <= '0;
    // the strobe is sampled at the next edge; read only after it has landed
    @(posedge sys_clk);
    rd_chk(OFS_OUT, 32'h0000_00db);
  endtask

  task automatic t_force();
    plan <= {8'hff, 8'h96, 8'hff, 8'h0f, 8'h3c, 8'h28, 24'h00_0000};
    @(posedge sys_clk);
    pads(24'h0f_0b96);
    plan <= {8'h0f, 8'h06, 8'h0f, 8'h05, 8'h3c, 8'h28, 24'h00_0000};
    @(posedge sys_clk);
    pads(24'h35_2106);
    plan <= '0;
  endtask

  task automatic t_sleep();
    pad_in <= 8'hff;
    ext_irq_en <= 8'h0f;
    wr(OFS_EDGE, 32'h0000_ffff);
    wr(OFS_FLAG, 32'h0000_00ff);
    plan <= {56'h0, 8'h30, 8'h10};
    // forces land on the same edge that raises sleep, so a forced pin never sees a one-cycle clamp
    @(posedge sys_clk);
    deep_sleep <= 1'b1;
    @(posedge sys_clk);
    ins(24'hff_1f1f);
    rd_chk(OFS_IN, 32'h0000_001f);
    chk({24'h0, raw_seen}, 32'h0000_001f);
    rd_chk(OFS_FLAG, 32'h0000_0000);
    plan <= '0;
    deep_sleep <= 1'b0;
    @(posedge sys_clk);
    ins(24'hff_ffff);
    repeat (3) @(posedge sys_clk);
    rd_chk(OFS_FLAG, 32'h0000_00e0);
    chk({24'h0, pin_edge_flag}, 32'h0000_00e0);
    // pin0 any change, pin1 falling, pin2 rising: a falling step hits only the first two
    wr(OFS_EDGE, 32'h0000_0039);
    wr(OFS_FLAG, 32'h0000_00ff);
    pad_in <= 8'hf8;
    repeat (3) @(posedge sys_clk);
    rd_chk(OFS_FLAG, 32'h0000_0003);
    chk({24'h0, pin_edge_flag}, 32'h0000_0003);
  endtask

  task automatic t_pullup_reset();
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_DIR, 32'h0000_0000);
    wr(OFS_OUT, 32'h0000_00ff);
    pads(24'h00_00ff);
    reset <= 1'b1;
    pads(24'h00_0000);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_chk(OFS_OUT, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset_values();
    t_gpio();
    t_toggle();
    t_force();
    t_sleep();
    t_pullup_reset();
    complete_run();
  end

  // the scenarios need under a hundred cycles; this cuts off a hung handshake
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule // port_pin_override_mux_tb
